// >>> signal_limit_supervisor.sv
// Signal limit supervisor: limit and hysteresis comparator with registers
`timescale 1ns/1ps
`include "sls_consts.svh"

module signal_limit_supervisor #(
    parameter int W = 32
) (
    input  wire logic                   clock_in,   // 10 MHz clock
    input  wire logic                   rst_in,     // Async reset, high
    input  wire logic signed [W-1:0]    signal_in,  // Monitored signal
    input  wire logic                   running_in, // Motor is running
    input  wire logic [`SLS_ADDR_W-1:0] addr_in,    // Register address
    input  wire logic [`SLS_BUS_W-1:0]  wdata_in,   // Write data
    input  wire logic                   wr_in,      // Write strobe
    input  wire logic                   rd_in,      // Read strobe
    output logic      [`SLS_BUS_W-1:0]  rdata_out,  // Read data
    output logic                        active_out, // Action active
    output logic                        warn_out,   // Warning raised
    output logic                        trip_out,   // Trip fault raised
    output logic                        irq_out     // Interrupt level
);
    localparam int E = W + 2;

    if (W < 2 || W > `SLS_BUS_W)
    begin : g_bad_width
        $error("signal_limit_supervisor: W must lie in 2..32");
    end

    // Refuse layouts that the status and event words cannot carry
    if (`SLS_STAT_MODE_LSB + `SLS_MODE_W > `SLS_BUS_W)
    begin : g_bad_mode_field
        $error("signal_limit_supervisor: mode field outside status word");
    end

    if (`SLS_EVT_N > `SLS_BUS_W)
    begin : g_bad_event_count
        $error("signal_limit_supervisor: too many interrupt events");
    end

    // Software settings
    logic [`SLS_MODE_W-1:0] mode_q;
    logic signed [W-1:0]    low_q;
    logic signed [W-1:0]    high_q;
    logic [W-1:0]           hyst_q;
    logic [`SLS_RESP_W-1:0] resp_q;
    logic [`SLS_EVT_N-1:0]  irq_stat_q;
    logic [`SLS_EVT_N-1:0]  irq_mask_q;

    // Block state
    logic                   active_q;
    logic                   active_d;
    sls_pkg::sup_out_t      out_q;
    sls_pkg::sup_out_t      out_d;
    logic [`SLS_BUS_W-1:0]  rdata_q;
    logic [`SLS_BUS_W-1:0]  rdata_d;
    logic                   irq_q;

    // Address decode
    wire wr_mode  = wr_in && (addr_in == `SLS_OFS_MODE);
    wire wr_low   = wr_in && (addr_in == `SLS_OFS_LOW);
    wire wr_high  = wr_in && (addr_in == `SLS_OFS_HIGH);
    wire wr_hyst  = wr_in && (addr_in == `SLS_OFS_HYST);
    wire wr_resp  = wr_in && (addr_in == `SLS_OFS_RESP);
    wire wr_istat = wr_in && (addr_in == `SLS_OFS_IRQ_STAT);
    wire wr_imask = wr_in && (addr_in == `SLS_OFS_IRQ_MASK);

    // A negative hysteresis write is stored as zero
    wire [W-1:0] hyst_wr = wdata_in[W-1] ? '0 : wdata_in[W-1:0];

    // Settings registers, one short block per setting
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            mode_q <= `SLS_MODE_RESET;
        else if (wr_mode)
            mode_q <= wdata_in[`SLS_MODE_W-1:0];
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            low_q <= W'(`SLS_LIMIT_RESET);
        else if (wr_low)
            low_q <= wdata_in[W-1:0];
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            high_q <= W'(`SLS_LIMIT_RESET);
        else if (wr_high)
            high_q <= wdata_in[W-1:0];
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            hyst_q <= W'(`SLS_HYST_RESET);
        else if (wr_hyst)
            hyst_q <= hyst_wr;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            resp_q <= `SLS_RESP_RESET;
        else if (wr_resp)
            resp_q <= wdata_in[`SLS_RESP_W-1:0];
    end

    // Mode decode; codes outside 1..6 act as disabled
    sls_pkg::sup_mode_t mode;
    assign mode = sls_pkg::sup_mode_t'(mode_q);

    wire abs_sel = (mode == sls_pkg::MODE_ABS_LOW)
                || (mode == sls_pkg::MODE_ABS_HIGH)
                || (mode == sls_pkg::MODE_ABS_BOTH);
    wire use_low = (mode == sls_pkg::MODE_LOW)
                || (mode == sls_pkg::MODE_ABS_LOW);
    wire use_high = (mode == sls_pkg::MODE_HIGH)
                 || (mode == sls_pkg::MODE_ABS_HIGH);
    wire use_both = (mode == sls_pkg::MODE_BOTH)
                 || (mode == sls_pkg::MODE_ABS_BOTH);
    wire enabled = use_low || use_high || use_both;

    // Widened operands so the limit sums and magnitudes cannot overflow
    wire signed [E-1:0] sig_x  = E'(signal_in);
    wire signed [E-1:0] low_x  = E'(low_q);
    wire signed [E-1:0] high_x = E'(high_q);
    wire signed [E-1:0] half_x = signed'(E'(hyst_q >> 1));

    // Guard bits also leave room to negate the most negative signal
    wire signed [E-1:0] sig_abs  = sig_x[E-1] ? -sig_x : sig_x;
    wire signed [E-1:0] low_abs  = low_x[E-1] ? -low_x : low_x;
    wire signed [E-1:0] high_abs = high_x[E-1] ? -high_x : high_x;

    wire signed [E-1:0] sig_v  = abs_sel ? sig_abs : sig_x;
    wire signed [E-1:0] low_v  = abs_sel ? low_abs : low_x;
    wire signed [E-1:0] high_v = abs_sel ? high_abs : high_x;

    sls_pkg::band_cmp_t low_cmp;
    sls_pkg::band_cmp_t high_cmp;

    // The same half band serves every mode
    sls_band_cmp #(
        .E          (E)
    ) u_low_cmp (
        .value_in   (sig_v),
        .limit_in   (low_v),
        .half_in    (half_x),
        .cmp_out    (low_cmp)
    );

    sls_band_cmp #(
        .E          (E)
    ) u_high_cmp (
        .value_in   (sig_v),
        .limit_in   (high_v),
        .half_in    (half_x),
        .cmp_out    (high_cmp)
    );

    // Set and clear conditions per comparison family
    wire low_set   = low_cmp.below;
    wire low_clr   = low_cmp.above;
    wire high_set  = high_cmp.above;
    wire high_clr  = high_cmp.below;
    wire both_set  = high_cmp.above || low_cmp.below;
    wire both_clr  = high_cmp.below && low_cmp.above;

    wire set_cond = (use_low && low_set) || (use_high && high_set)
                 || (use_both && both_set);
    wire clr_cond = (use_low && low_clr) || (use_high && high_clr)
                 || (use_both && both_clr);

    // Set wins if both hold, though no mode lets both hold at once
    always_comb
    begin
        if (!enabled)
            active_d = 1'b0;
        else if (set_cond)
            active_d = 1'b1;
        else if (clr_cond)
            active_d = 1'b0;
        else
            active_d = active_q;
    end

    // Response selection works from the registered active state
    sls_pkg::sup_resp_t resp;
    assign resp = sls_pkg::sup_resp_t'(resp_q);

    // Running is used as it stands; a trip that needs it follows the
    // motor within one cycle, with no extra filtering
    wire trip_sel = (resp == sls_pkg::RESP_TRIP)
                 || ((resp == sls_pkg::RESP_TRIP_RUN) && running_in);

    always_comb
    begin
        out_d.active  = active_q;
        out_d.warning = active_q && (resp == sls_pkg::RESP_WARN);
        out_d.trip    = active_q && trip_sel;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            active_q <= 1'b0;
            out_q    <= '0;
        end
        else
        begin
            active_q <= active_d;
            out_q    <= out_d;
        end
    end

    // Events for the interrupt status, taken from the output edges
    // Each fires once, in the cycle before its output register rises; the fall event fires in the cycle before active falls
    logic [`SLS_EVT_N-1:0] evt;
    assign evt[`SLS_EVT_RISE] = out_d.active && !out_q.active;
    assign evt[`SLS_EVT_FALL] = !out_d.active && out_q.active;
    assign evt[`SLS_EVT_WARN] = out_d.warning && !out_q.warning;
    assign evt[`SLS_EVT_TRIP] = out_d.trip && !out_q.trip;

    // Sticky status, write one to clear; a new event beats the clear
    for (genvar i = 0; i < `SLS_EVT_N; i++)
    begin : g_irq
        wire clr = wr_istat && wdata_in[i];
        always_ff @(posedge clock_in or posedge rst_in)
        begin
            if (rst_in)
                irq_stat_q[i] <= 1'b0;
            else
                irq_stat_q[i] <= evt[i] || (irq_stat_q[i] && !clr);
        end
    end

    // The level output is registered, so it lags the status by one cycle
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_mask_q <= `SLS_EVT_RESET;
            irq_q      <= 1'b0;
        end
        else
        begin
            if (wr_imask)
                irq_mask_q <= wdata_in[`SLS_EVT_N-1:0];
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read mux; unmapped addresses read as zero
    // Read data stand for one cycle only, so a stale word is never re-read
    logic [`SLS_BUS_W-1:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[`SLS_STAT_ACTIVE] = out_q.active;
        status_word[`SLS_STAT_WARN]   = out_q.warning;
        status_word[`SLS_STAT_TRIP]   = out_q.trip;
        status_word[`SLS_STAT_MODE_LSB +: `SLS_MODE_W] = mode_q;
    end

    always_comb
    begin
        rdata_d = '0;
        if (rd_in)
        begin
            case (addr_in)
                `SLS_OFS_MODE:     rdata_d = `SLS_BUS_W'(mode_q);
                `SLS_OFS_LOW:      rdata_d = `SLS_BUS_W'(low_q);
                `SLS_OFS_HIGH:     rdata_d = `SLS_BUS_W'(high_q);
                `SLS_OFS_HYST:     rdata_d = `SLS_BUS_W'(hyst_q);
                `SLS_OFS_RESP:     rdata_d = `SLS_BUS_W'(resp_q);
                `SLS_OFS_STATUS:   rdata_d = status_word;
                `SLS_OFS_IRQ_STAT: rdata_d = `SLS_BUS_W'(irq_stat_q);
                `SLS_OFS_IRQ_MASK: rdata_d = `SLS_BUS_W'(irq_mask_q);
                default:           rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign rdata_out  = rdata_q;
    assign active_out = out_q.active;
    assign warn_out   = out_q.warning;
    assign trip_out   = out_q.trip;
    assign irq_out    = irq_q;
endmodule // signal_limit_supervisor

// >>> sls_consts.svh
// Register offsets, field positions and reset values of the supervisor
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH

`define SLS_ADDR_W          8
`define SLS_BUS_W           32

`define SLS_OFS_MODE        8'h00
`define SLS_OFS_LOW         8'h04
`define SLS_OFS_HIGH        8'h08
`define SLS_OFS_HYST        8'h0c
`define SLS_OFS_RESP        8'h10
`define SLS_OFS_STATUS      8'h14
`define SLS_OFS_IRQ_STAT    8'h18
`define SLS_OFS_IRQ_MASK    8'h1c

`define SLS_MODE_W          4
`define SLS_RESP_W          2
`define SLS_MODE_RESET      4'h0
`define SLS_RESP_RESET      2'h0
`define SLS_LIMIT_RESET     32'h0000_0000
`define SLS_HYST_RESET      32'h0000_0000

`define SLS_STAT_ACTIVE     0
`define SLS_STAT_WARN       1
`define SLS_STAT_TRIP       2
`define SLS_STAT_MODE_LSB   4

`define SLS_EVT_N           4
`define SLS_EVT_RISE        0
`define SLS_EVT_FALL        1
`define SLS_EVT_WARN        2
`define SLS_EVT_TRIP        3
`define SLS_EVT_RESET       4'h0

`endif

// >>> sls_pkg.sv
// Types shared by the signal limit supervisor files
package sls_pkg;

    typedef enum logic [3:0] {
        MODE_DISABLED = 4'h0,
        MODE_LOW      = 4'h1,
        MODE_HIGH     = 4'h2,
        MODE_ABS_LOW  = 4'h3,
        MODE_ABS_HIGH = 4'h4,
        MODE_BOTH     = 4'h5,
        MODE_ABS_BOTH = 4'h6
    } sup_mode_t;

    typedef enum logic [1:0] {
        RESP_NONE      = 2'h0,
        RESP_WARN      = 2'h1,
        RESP_TRIP      = 2'h2,
        RESP_TRIP_RUN  = 2'h3
    } sup_resp_t;

    typedef struct packed {
        logic active;
        logic warning;
        logic trip;
    } sup_out_t;

    typedef struct packed {
        logic above;
        logic below;
    } band_cmp_t;

endpackage

// >>> sls_band_cmp.sv
// Compares one value against a limit widened by a half band on each side
`timescale 1ns/1ps
module sls_band_cmp #(
    parameter int E = 34
) (
    input  wire logic signed [E-1:0] value_in,  // Value under test
    input  wire logic signed [E-1:0] limit_in,  // Centre of the band
    input  wire logic signed [E-1:0] half_in,   // Half band, never negative
    output sls_pkg::band_cmp_t       cmp_out    // Above and below the band
);
    logic signed [E-1:0] upper;
    logic signed [E-1:0] lower;

    // Two guard bits in E keep these sums from wrapping
    assign upper = limit_in + half_in;
    assign lower = limit_in - half_in;

    assign cmp_out.above = value_in > upper;
    assign cmp_out.below = value_in < lower;
endmodule // sls_band_cmp

// >>> signal_limit_supervisor_checker.sv
// Port level assertions for the signal limit supervisor
`timescale 1ns/1ps
`include "sls_consts.svh"
module signal_limit_supervisor_checker #(
    parameter int W = 32
) (
    input wire logic                   clock_in,   // Clock
    input wire logic                   rst_in,     // Reset
    input wire logic signed [W-1:0]    signal_in,  // Monitored signal
    input wire logic                   running_in, // Motor running
    input wire logic [`SLS_ADDR_W-1:0] addr_in,    // Address
    input wire logic [`SLS_BUS_W-1:0]  wdata_in,   // Write data
    input wire logic                   wr_in,      // Write strobe
    input wire logic                   rd_in,      // Read strobe
    input wire logic [`SLS_BUS_W-1:0]  rdata_out,  // Read data
    input wire logic                   active_out, // Action active
    input wire logic                   warn_out,   // Warning
    input wire logic                   trip_out,   // Trip
    input wire logic                   irq_out     // Interrupt
);
    logic [3:0]         mode_q;
    logic signed [33:0] low_q;
    logic signed [33:0] high_q;
    logic signed [33:0] half_q;
    wire  signed [33:0] sig_w    = 34'(signal_in);
    wire                low_set  = sig_w < low_q - half_q;
    wire                low_clr  = sig_w > low_q + half_q;
    wire                high_set = sig_w > high_q + half_q;
    wire                high_clr = sig_w < high_q - half_q;

    // Shadow copies of the settings, so thresholds are known at the ports
    always_ff @(posedge clock_in or posedge rst_in)
        if (rst_in)
        begin
            mode_q <= 4'h0;
            low_q  <= '0;
            high_q <= '0;
            half_q <= '0;
        end
        else if (wr_in)
        begin
            if (addr_in == 8'h00)
                mode_q <= wdata_in[3:0];
            if (addr_in == 8'h04)
                low_q <= 34'($signed(wdata_in));
            if (addr_in == 8'h08)
                high_q <= 34'($signed(wdata_in));
            if (addr_in == 8'h0c)
                half_q <= wdata_in[31] ? '0 : 34'(wdata_in[31:1]);
        end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    mode_off_a: assert property (
        (mode_q == 4'h0) [*3] |-> !active_out)
        else $error("active while disabled");
    low_set_a: assert property (
        (mode_q == 4'h1 && low_set) [*3] |-> active_out)
        else $error("low mode did not set");
    low_clr_a: assert property (
        (mode_q == 4'h1 && low_clr) [*3] |-> !active_out)
        else $error("low mode did not clear");
    high_set_a: assert property (
        (mode_q == 4'h2 && high_set) [*3] |-> active_out)
        else $error("high mode did not set");
    high_clr_a: assert property (
        (mode_q == 4'h2 && high_clr) [*3] |-> !active_out)
        else $error("high mode did not clear");
    warn_act_a: assert property (
        warn_out |-> active_out)
        else $error("warning without action");
    trip_act_a: assert property (
        trip_out |-> active_out)
        else $error("trip without action");
    resp_one_a: assert property (
        !(warn_out && trip_out))
        else $error("warning and trip together");

    cover property (mode_q == 4'h6 && active_out);
    cover property (trip_out && running_in);
    cover property (irq_out);
endmodule // signal_limit_supervisor_checker

bind signal_limit_supervisor signal_limit_supervisor_checker #(.W(W)) i_chk (
    .clock_in(clock_in), .rst_in(rst_in), .signal_in(signal_in),
    .running_in(running_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .active_out(active_out), .warn_out(warn_out), .trip_out(trip_out),
    .irq_out(irq_out));

// >>> signal_limit_supervisor_tb_top.sv
// Self-checking bench for the signal limit supervisor
`timescale 1ns/1ps
`include "sls_consts.svh"
module signal_limit_supervisor_tb_top;
    logic               clock_in;
    logic               rst_in;
    logic signed [31:0] signal_in;
    logic               running_in;
    logic [7:0]         addr_in;
    logic [31:0]        wdata_in;
    logic               wr_in;
    logic               rd_in;
    logic [31:0]        rdata_out;
    logic               active_out;
    logic               warn_out;
    logic               trip_out;
    logic               irq_out;
    int                 error_cnt = 0;
    int                 n_checks = 0;
    int                 cycles = 0;

    signal_limit_supervisor i_signal_limit_supervisor (
        .clock_in(clock_in), .rst_in(rst_in), .signal_in(signal_in),
        .running_in(running_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .active_out(active_out), .warn_out(warn_out),
        .trip_out(trip_out), .irq_out(irq_out));

    initial
    begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Far above the few hundred cycles the scenarios need
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            error_cnt++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        chk("rdata", exp, rdata_out);
    endtask

    // Output lags the signal by two edges; four leaves margin for a level
    task automatic sig(input int v, input logic exp);
        @(posedge clock_in);
        signal_in <= v;
        repeat (4) @(posedge clock_in);
        #1;
        chk("active", {31'h0, exp}, {31'h0, active_out});
    endtask

    task automatic t_low();
        wr(8'h04, 32'h0000_0064);
        wr(8'h0c, 32'h0000_0014);
        sig(120, 1'b0);
        wr(8'h00, 32'h0000_0001);
        sig(95, 1'b0);
        sig(89, 1'b1);
        rd(8'h14, 32'h0000_0011);
        sig(105, 1'b1);
        sig(110, 1'b1);
        sig(111, 1'b0);
    endtask

    task automatic t_irq();
        rd(8'h18, 32'h0000_0003);
        chk("irq", 32'h0, {31'h0, irq_out});
        wr(8'h1c, 32'h0000_0001);
        repeat (3) @(posedge clock_in);
        #1;
        chk("irq", 32'h1, {31'h0, irq_out});
        wr(8'h18, 32'h0000_0001);
        repeat (3) @(posedge clock_in);
        #1;
        chk("irq", 32'h0, {31'h0, irq_out});
        rd(8'h18, 32'h0000_0002);
        wr(8'h1c, 32'h0000_0000);
    endtask

    task automatic t_high_both();
        wr(8'h08, 32'h0000_00c8);
        wr(8'h00, 32'h0000_0002);
        sig(211, 1'b1);
        sig(195, 1'b1);
        sig(189, 1'b0);
        wr(8'h00, 32'h0000_0005);
        sig(211, 1'b1);
        sig(150, 1'b0);
        sig(89, 1'b1);
        sig(150, 1'b0);
    endtask

    task automatic t_abs();
        wr(8'h04, 32'hffff_ff9c);
        wr(8'h08, 32'hffff_ff38);
        rd(8'h04, 32'hffff_ff9c);
        wr(8'h00, 32'h0000_0003);
        sig(-89, 1'b1);
        sig(-111, 1'b0);
        wr(8'h00, 32'h0000_0004);
        sig(-211, 1'b1);
        sig(189, 1'b0);
        wr(8'h00, 32'h0000_0006);
        sig(211, 1'b1);
        sig(150, 1'b0);
        sig(-89, 1'b1);
    endtask

    // Reset in mid-run while the output stands high
    task automatic t_reset();
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        chk("active", 32'h0, {31'h0, active_out});
        @(posedge clock_in);
        rst_in <= 1'b0;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'h0000_0001);
        sig(-89, 1'b1);
    endtask

    task automatic t_resp();
        int i;
        for (i = 0; i < 5; i++)
        begin
            wr(8'h10, (i > 3) ? 32'h3 : 32'(i));
            running_in <= (i == 4);
            repeat (4) @(posedge clock_in);
            #1;
            chk("warn", 32'(i == 1), {31'h0, warn_out});
            chk("trip", 32'(i == 2 || i == 4), {31'h0, trip_out});
        end
        wr(8'h00, 32'h0000_0007);
        sig(-89, 1'b0);
        wr(8'h00, 32'h0000_0000);
        sig(-89, 1'b0);
        wr(8'h0c, 32'h8000_0014);
        rd(8'h0c, 32'h0);
    endtask

    initial
    begin
        rst_in     = 1'b1;
        signal_in  = '0;
        running_in = 1'b0;
        addr_in    = '0;
        wdata_in   = '0;
        wr_in      = 1'b0;
        rd_in      = 1'b0;
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0);
        sig(-5, 1'b0);
        t_low();
        t_irq();
        t_high_both();
        t_abs();
        t_reset();
        t_resp();
        summarize();
    end
endmodule // signal_limit_supervisor_tb_top
